/* rtl/enc_out_map.svh */
// Constants of the encoder output generator
`ifndef ENC_OUT_MAP_SVH
`define ENC_OUT_MAP_SVH

`define ENC_COUNTS_PER_TOOTH 7'h50
`define ENC_TOOTH_HIGH       7'h28
`define ENC_TEETH_PER_REV    6'h32
`define ENC_MISSING_TOOTH    6'h31
`define ENC_DIV_MIN          9'h001
`define ENC_DIV_MAX          9'h100
`define ENC_STEP_SHIFT       1
`define ENC_SYNC_DEPTH       3

`endif

/* rtl/enc_out_pkg.sv */
// Types of the encoder output generator
package enc_out_pkg;

    typedef enum logic [1:0] {
        FMT_STEP_DIR,
        FMT_UP_DOWN,
        FMT_QUAD
    } fmt_t;

    typedef struct packed {
        logic       monitor_enable_cmd;
        logic       monitor_disable_cmd;
        logic       divider_set_cmd;
        logic       divider_trigger_cmd;
        logic       divider_clear_cmd;
        logic [8:0] divisor;
        fmt_t       fmt;
        logic       ext_source;
    } cmd_t;

    typedef struct packed {
        logic mon_on;
        logic mon_err;
        logic mod_on;
        logic trig_on;
        logic [8:0] divisor;
        fmt_t fmt;
        logic ext_source;
    } status_t;

endpackage

/* rtl/encoder_output_generator.sv */
// Encoder output stage: raw mirror, index channel and modulo divider
// Operation
// - Monitor mirrors A, B, index onto lines 1-3
// - Monitor enable command starts raw mirroring if lines 1-3 are all inputs
// - Monitor disable command stops raw mirroring
// - Raw path is unscaled quadrature only
// - Index channel: 50 teeth per rev, one missing
// - Divisor 1 to 256, only divides down
// - Step formats: one pulse per two counts
// - Quadrature: one cycle per four counts
// - Divisor further divides rate by its value
// - Formats: step/dir, up/down, quadrature
// - Divider set command drives lines 6 and 7
// - Set command carries divisor, format, source
// - Trigger mode gates output by line 1 level
// - Divider clear command stops modulo output
`timescale 1ns/1ps
`include "enc_out_map.svh"

module encoder_output_generator (
    input  wire logic               sys_clk,
    input  wire logic               srst,
    input  wire logic               int_a,
    input  wire logic               int_b,
    input  wire logic               int_index,
    input  wire logic               ext_a,
    input  wire logic               ext_b,
    input  wire logic               line1_in,
    input  wire logic [2:0]         lines_are_inputs,
    input  wire enc_out_pkg::cmd_t  cmd,
    output logic                    line1_out,
    output logic                    line2_out,
    output logic                    line3_out,
    output logic                    lines13_oe,
    output logic                    line6_out,
    output logic                    line7_out,
    output logic                    lines67_oe,
    output logic                    buf_a_out,
    output logic                    buf_b_out,
    output logic                    buf_z_out,
    output enc_out_pkg::status_t    status
);
    typedef struct packed {
        enc_out_pkg::status_t st;
        logic signed [10:0]   rem;
        logic [1:0]           q;
        logic                 dir;
        logic [2:0]           sync_a;
        logic [2:0]           sync_b;
        logic [2:0]           sync_t;
        logic                 flt_a;
        logic                 flt_b;
        logic                 flt_t;
        logic [1:0]           prev_int;
        logic [1:0]           prev_ext;
        logic [6:0]           zcnt;
        logic [5:0]           zidx;
        logic [2:0]           raw;
        logic                 oe13;
        logic [1:0]           mod_lines;
        logic                 oe67;
        logic [2:0]           bufo;
    } state_t;
    state_t s;
    state_t next_s;
    // Gray position of an {a,b} pair: 00,10,11,01 is the up direction
    function automatic logic [1:0] gray_pos(input logic [1:0] ab);
        case (ab)
            2'h0:    gray_pos = 2'h0;
            2'h2:    gray_pos = 2'h1;
            2'h3:    gray_pos = 2'h2;
            default: gray_pos = 2'h3;
        endcase
    endfunction
    // Returns {count, up} for one quadrature transition
    function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
        logic [1:0] d;
        d = gray_pos(cur) - gray_pos(prev);
        quad_step = {(d == 2'h1) || (d == 2'h3), d == 2'h1};
    endfunction
    // Input counts per output event for a format and divisor
    function automatic logic signed [10:0] threshold(input enc_out_pkg::fmt_t f,
                                                      input logic [8:0] dv);
        logic [10:0] t;
        t = {2'h0, dv};
        if (f != enc_out_pkg::FMT_QUAD)
            t = t << `ENC_STEP_SHIFT;
        threshold = signed'(t);
    endfunction
    logic [1:0]         int_step;
    logic [1:0]         ext_step;
    logic [1:0]         src_step;
    logic               gate;
    logic               emit_up;
    logic               emit_dn;
    logic signed [10:0] thr;
    logic               mon_ok;
    logic [8:0]         new_div;
    always_comb
    begin
        next_s   = s;
        emit_up  = 1'b0;
        emit_dn  = 1'b0;
        // Pin inputs pass three flops; a change counts once the last two agree
        next_s.sync_a = {s.sync_a[1:0], ext_a};
        next_s.sync_b = {s.sync_b[1:0], ext_b};
        next_s.sync_t = {s.sync_t[1:0], line1_in};
        next_s.flt_a = (s.sync_a[1] == s.sync_a[2]) ? s.sync_a[2] : s.flt_a;
        next_s.flt_b = (s.sync_b[1] == s.sync_b[2]) ? s.sync_b[2] : s.flt_b;
        next_s.flt_t = (s.sync_t[1] == s.sync_t[2]) ? s.sync_t[2] : s.flt_t;
        int_step = quad_step(s.prev_int, {int_a, int_b});
        ext_step = quad_step(s.prev_ext, {s.flt_a, s.flt_b});
        next_s.prev_int = {int_a, int_b};
        next_s.prev_ext = {s.flt_a, s.flt_b};
        // Monitor commands; enabling with lines 1-3 not inputs is an error
        mon_ok = (lines_are_inputs == 3'h7);
        if (cmd.monitor_disable_cmd)
        begin
            next_s.st.mon_on  = 1'b0;
            next_s.st.mon_err = 1'b0;
        end
        else if (cmd.monitor_enable_cmd)
        begin
            next_s.st.mon_on  = mon_ok;
            if (!mon_ok)
                next_s.st.mon_err = 1'b1;
        end
        next_s.oe13 = next_s.st.mon_on;
        next_s.raw  = next_s.st.mon_on ? {int_index, int_b, int_a} : 3'h0;
        // Index channel built from the internal count position
        if (int_step[1])
        begin
            if (int_step[0])
            begin
                if (s.zcnt == `ENC_COUNTS_PER_TOOTH - 7'h01)
                begin
                    next_s.zcnt = 7'h00;
                    next_s.zidx = (s.zidx == `ENC_MISSING_TOOTH) ? 6'h00 : s.zidx + 6'h01;
                end
                else
                    next_s.zcnt = s.zcnt + 7'h01;
            end
            else if (s.zcnt == 7'h00)
            begin
                next_s.zcnt = `ENC_COUNTS_PER_TOOTH - 7'h01;
                next_s.zidx = (s.zidx == 6'h00) ? `ENC_MISSING_TOOTH : s.zidx - 6'h01;
            end
            else
                next_s.zcnt = s.zcnt - 7'h01;
        end
        next_s.bufo = {(next_s.zcnt < `ENC_TOOTH_HIGH) &&
                       (next_s.zidx != `ENC_MISSING_TOOTH), int_b, int_a};
        // Divider commands; clear wins, trigger is a set with gating on
        new_div = cmd.divisor;
        if (new_div < `ENC_DIV_MIN)
            new_div = `ENC_DIV_MIN;
        else if (new_div > `ENC_DIV_MAX)
            new_div = `ENC_DIV_MAX;
        if (cmd.divider_clear_cmd)
        begin
            next_s.st.mod_on  = 1'b0;
            next_s.st.trig_on = 1'b0;
        end
        else if (cmd.divider_set_cmd || cmd.divider_trigger_cmd)
        begin
            next_s.st.mod_on     = 1'b1;
            next_s.st.trig_on    = cmd.divider_trigger_cmd;
            next_s.st.divisor    = new_div;
            next_s.st.fmt        = cmd.fmt;
            next_s.st.ext_source = cmd.ext_source;
            next_s.q             = 2'h0;
            next_s.dir           = 1'b0;
        end
        src_step = s.st.ext_source ? ext_step : int_step;
        gate     = s.st.mod_on && (!s.st.trig_on || s.flt_t);
        thr      = threshold(s.st.fmt, s.st.divisor);
        if (gate && src_step[1])
        begin
            if (src_step[0])
            begin
                if (s.rem == thr - 11'sd1)
                begin
                    next_s.rem = 11'sd0;
                    emit_up    = 1'b1;
                end
                else
                    next_s.rem = s.rem + 11'sd1;
            end
            else if (s.rem == 11'sd1 - thr)
            begin
                next_s.rem = 11'sd0;
                emit_dn    = 1'b1;
            end
            else
                next_s.rem = s.rem - 11'sd1;
        end
        if (cmd.divider_set_cmd || cmd.divider_trigger_cmd)
            next_s.rem = 11'sd0;
        if (emit_up)
            next_s.dir = 1'b1;
        else if (emit_dn)
            next_s.dir = 1'b0;
        if (emit_up)
            next_s.q = s.q + 2'h1;
        else if (emit_dn)
            next_s.q = s.q - 2'h1;

        case (next_s.st.fmt)
            enc_out_pkg::FMT_STEP_DIR: next_s.mod_lines = {next_s.dir, emit_up | emit_dn};
            enc_out_pkg::FMT_UP_DOWN:  next_s.mod_lines = {emit_dn, emit_up};
            enc_out_pkg::FMT_QUAD:
                next_s.mod_lines = {next_s.q[1], next_s.q[1] ^ next_s.q[0]};
            default:                   next_s.mod_lines = 2'h0;
        endcase
        if (!next_s.st.mod_on)
            next_s.mod_lines = 2'h0;
        next_s.oe67 = next_s.st.mod_on;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s            <= '0;
            s.st.divisor <= `ENC_DIV_MIN;
            s.st.fmt     <= enc_out_pkg::FMT_STEP_DIR;
        end
        else
            s <= next_s;
    end

    assign line1_out  = s.raw[0];
    assign line2_out  = s.raw[1];
    assign line3_out  = s.raw[2];
    assign lines13_oe = s.oe13;
    assign line6_out  = s.mod_lines[0];
    assign line7_out  = s.mod_lines[1];
    assign lines67_oe = s.oe67;
    assign buf_a_out  = s.bufo[0];
    assign buf_b_out  = s.bufo[1];
    assign buf_z_out  = s.bufo[2];
    assign status     = s.st;

    a_mirror_lines: assert property (@(posedge sys_clk) disable iff (srst)
        lines13_oe |-> ({line3_out, line2_out, line1_out} ==
                        {$past(int_index), $past(int_b), $past(int_a)}))
        else $error("raw mirror does not follow internal encoder");
    a_mon_enable: assert property (@(posedge sys_clk) disable iff (srst)
        (cmd.monitor_enable_cmd && !cmd.monitor_disable_cmd && lines_are_inputs == 3'h7)
        |=> lines13_oe ##1 (lines13_oe || $past(cmd.monitor_disable_cmd)))
        else $error("monitor enable did not drive lines 1-3");
    a_mon_disable: assert property (@(posedge sys_clk) disable iff (srst)
        cmd.monitor_disable_cmd |=> (!lines13_oe && !line1_out && !line2_out && !line3_out))
        else $error("monitor disable left lines driven");
    a_mon_error: assert property (@(posedge sys_clk) disable iff (srst)
        (cmd.monitor_enable_cmd && !cmd.monitor_disable_cmd && lines_are_inputs != 3'h7)
        |=> (status.mon_err && !lines13_oe))
        else $error("monitor enable with output lines not flagged");
    a_index_missing: assert property (@(posedge sys_clk) disable iff (srst)
        (s.zidx == `ENC_MISSING_TOOTH) |-> !buf_z_out)
        else $error("index tooth present in missing slot");
    a_index_high: assert property (@(posedge sys_clk) disable iff (srst)
        (!$past(srst) && s.zidx != `ENC_MISSING_TOOTH && s.zcnt < `ENC_TOOTH_HIGH) |-> buf_z_out)
        else $error("index tooth low in first half");
    a_divisor_range: assert property (@(posedge sys_clk) disable iff (srst)
        (status.divisor >= `ENC_DIV_MIN) && (status.divisor <= `ENC_DIV_MAX))
        else $error("divisor out of range");
    a_step_ratio: assert property (@(posedge sys_clk) disable iff (srst)
        (status.fmt == enc_out_pkg::FMT_STEP_DIR && line6_out && $stable(status.divisor))
        |-> ($past(s.rem) == 11'(signed'({2'h0, status.divisor}) <<< 1) - 11'sd1) ||
            ($past(s.rem) == 11'sd1 - 11'(signed'({2'h0, status.divisor}) <<< 1)))
        else $error("step pulse not at two counts times divisor");
    a_quad_gray: assert property (@(posedge sys_clk) disable iff (srst)
        (status.fmt == enc_out_pkg::FMT_QUAD && $past(status.fmt == enc_out_pkg::FMT_QUAD)
         && lines67_oe && $past(lines67_oe))
        |-> ($countones({line7_out, line6_out} ^ $past({line7_out, line6_out})) <= 1))
        else $error("quadrature output moved two bits at once");
    a_set_enable: assert property (@(posedge sys_clk) disable iff (srst)
        (cmd.divider_set_cmd && !cmd.divider_clear_cmd)
        |=> (lines67_oe && s.rem == 11'sd0 && status.fmt == $past(cmd.fmt)))
        else $error("set command did not enable modulo path");
    a_trig_gate: assert property (@(posedge sys_clk) disable iff (srst)
        (status.trig_on && !s.flt_t && !cmd.divider_set_cmd && !cmd.divider_trigger_cmd)
        |=> $stable(s.rem))
        else $error("modulo path counted while trigger low");
    a_clear_stop: assert property (@(posedge sys_clk) disable iff (srst)
        cmd.divider_clear_cmd |=> (!lines67_oe && !line6_out && !line7_out))
        else $error("clear left modulo lines active");
    a_rem_bound: assert property (@(posedge sys_clk) disable iff (srst)
        status.mod_on |-> (s.rem < thr) && (s.rem > -thr))
        else $error("remainder left its range");

endmodule

/* tb/follower_model.sv */
// Following controller model that decodes the modulo output lines
`timescale 1ns/1ps

module follower_model (
    input  wire logic              sys_clk,
    input  wire logic              line6,
    input  wire logic              line7,
    input  wire logic              oe,
    input  wire enc_out_pkg::fmt_t fmt,
    output int                     count
);
    logic [1:0] prev = 2'h0;
    int         step;

    initial count = 0;

    // Decodes with the format that the set command selected
    always @(posedge sys_clk)
    begin
        step = 0;
        if (fmt == enc_out_pkg::FMT_STEP_DIR && line6)
            step = line7 ? 1 : -1;
        if (fmt == enc_out_pkg::FMT_UP_DOWN)
            step = int'(line6) - int'(line7);
        if (fmt == enc_out_pkg::FMT_QUAD && {line6, line7} != prev)
            step = ({prev, line6, line7} inside {4'h2, 4'hb, 4'hd, 4'h4}) ? 1 : -1;
        prev <= (oe && fmt == enc_out_pkg::FMT_QUAD) ? {line6, line7} : 2'h0;
        count <= count + step;
    end
endmodule

/* tb/test_encoder_output_generator.sv */
// Self-checking testbench of the encoder output generator
`timescale 1ns/1ps
`include "enc_out_map.svh"

module test_encoder_output_generator;
    localparam enc_out_pkg::fmt_t sd = enc_out_pkg::FMT_STEP_DIR;
    localparam enc_out_pkg::fmt_t ud = enc_out_pkg::FMT_UP_DOWN;
    localparam enc_out_pkg::fmt_t qd = enc_out_pkg::FMT_QUAD;
    localparam logic [4:0]        m_on = 5'h10;
    localparam logic [4:0]        m_off = 5'h08;
    localparam logic [4:0]        d_set = 5'h04;
    localparam logic [4:0]        d_trig = 5'h02;
    localparam logic [4:0]        d_clr = 5'h01;

    logic                 sys_clk = 1'b0;
    logic                 srst = 1'b1;
    logic                 int_a = 1'b0, int_b = 1'b0, int_index = 1'b0;
    logic                 ext_a = 1'b0, ext_b = 1'b0, line1_in = 1'b0;
    logic [2:0]           lines_are_inputs = 3'h7;
    enc_out_pkg::cmd_t    cmd = '0;
    enc_out_pkg::fmt_t    fmt_sel = sd;
    logic                 line1_out, line2_out, line3_out, lines13_oe;
    logic                 line6_out, line7_out, lines67_oe;
    logic                 buf_a_out, buf_b_out, buf_z_out, z_d = 1'b0;
    enc_out_pkg::status_t status;
    logic [1:0]           pi = 2'h0, pe = 2'h0;
    int                   count, z_rises = 0, n_mismatch = 0, comparisons = 0;

    always #2.5 sys_clk = ~sys_clk;

    encoder_output_generator encoder_output_generator_inst (
        .sys_clk, .srst, .int_a, .int_b, .int_index, .ext_a, .ext_b, .line1_in,
        .lines_are_inputs, .cmd, .line1_out, .line2_out, .line3_out, .lines13_oe,
        .line6_out, .line7_out, .lines67_oe, .buf_a_out, .buf_b_out, .buf_z_out, .status
    );

    follower_model follower_model_inst (
        .sys_clk, .line6(line6_out), .line7(line7_out), .oe(lines67_oe), .fmt(fmt_sel), .count
    );

    always @(posedge sys_clk)
    begin
        if (buf_z_out && !z_d)
            z_rises++;
        z_d = buf_z_out;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic issue(input logic [4:0] bits, input logic [8:0] dv,
                         input enc_out_pkg::fmt_t f, input logic ext);
        @(posedge sys_clk);
        cmd <= {bits, dv, f, ext};
        if (bits[2] | bits[1])
            fmt_sel <= f;
        @(posedge sys_clk);
        cmd <= '0;
        repeat (3) @(posedge sys_clk);
    endtask

    // One count every four cycles, so the external synchroniser keeps up
    task automatic move(input int n, input logic ext);
        logic [1:0] d;
        d = (n < 0) ? 2'h3 : 2'h1;
        repeat ((n < 0) ? -n : n)
        begin
            @(posedge sys_clk);
            if (ext)
                pe = pe + d;
            else
                pi = pi + d;
            {int_a, int_b} <= {pi[0] ^ pi[1], pi[1]};
            {ext_a, ext_b} <= {pe[0] ^ pe[1], pe[1]};
            repeat (3) @(posedge sys_clk);
        end
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic mv(input int n, input logic ext, input int exp);
        int base;
        base = count;
        move(n, ext);
        check(count - base, exp);
    endtask

    task automatic t_index();
        z_rises = 0;
        move(4000, 1'b0);
        check(z_rises, 49);
        check(buf_a_out, int_a);
    endtask

    task automatic t_monitor();
        @(posedge sys_clk);
        lines_are_inputs <= 3'h3;
        issue(m_on, 9'h001, sd, 1'b0);
        check(lines13_oe, 1'b0);
        check(status.mon_err, 1'b1);
        issue(m_off, 9'h001, sd, 1'b0);
        check(status.mon_err, 1'b0);
        lines_are_inputs <= 3'h7;
        int_index <= 1'b1;
        issue(m_on, 9'h001, sd, 1'b0);
        check({line1_out, line2_out, line3_out, lines13_oe}, {int_a, int_b, 2'h3});
        check(status.mon_on, 1'b1);
        move(1, 1'b0);
        check({line1_out, line2_out}, {int_a, int_b});
        check({buf_a_out, buf_b_out}, {int_a, int_b});
        issue(m_off, 9'h001, sd, 1'b0);
        check({line1_out, line3_out, lines13_oe}, 3'h0);
    endtask

    task automatic t_divider();
        issue(d_set, 9'h000, sd, 1'b0);
        check(status.divisor, `ENC_DIV_MIN);
        check(lines67_oe, 1'b1);
        check(status.mod_on, 1'b1);
        issue(d_set, 9'h1ff, sd, 1'b0);
        check(status.divisor, `ENC_DIV_MAX);
        issue(d_set, 9'h001, sd, 1'b0);
        mv(8, 1'b0, 4);
        mv(-4, 1'b0, -2);
        issue(d_set, 9'h003, ud, 1'b0);
        mv(5, 1'b0, 0);
        mv(7, 1'b0, 2);
        mv(-12, 1'b0, -2);
        issue(d_set, 9'h001, qd, 1'b0);
        check(status.fmt, qd);
        mv(8, 1'b0, 8);
        mv(-4, 1'b0, -4);
        issue(d_set, 9'h004, qd, 1'b0);
        mv(16, 1'b0, 4);
        issue(d_clr, 9'h001, sd, 1'b0);
        check({lines67_oe, line6_out, line7_out}, 3'h0);
        check(status.mod_on, 1'b0);
        mv(8, 1'b0, 0);
    endtask

    task automatic t_trigger();
        line1_in <= 1'b0;
        issue(d_trig, 9'h001, sd, 1'b1);
        check({status.trig_on, status.ext_source}, 2'h3);
        mv(8, 1'b1, 0);
        line1_in <= 1'b1;
        repeat (6) @(posedge sys_clk);
        mv(8, 1'b1, 4);
        mv(6, 1'b0, 0);
    endtask

    task automatic complete_run();
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_index();
        t_monitor();
        t_divider();
        t_trigger();
        complete_run();
    end

    initial
    begin
        #300000;
        n_mismatch++;
        complete_run();
    end
endmodule
